// ==== include/smi_pkg.sv ====
// Constants and types shared by the mode and interrupt source status block
`default_nettype none
package smi_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_FIFO_STATUS = 8'h00;
   localparam logic [7:0] OFS_ACC_FIRST = 8'h01;
   localparam logic [7:0] OFS_ACC_LAST = 8'h06;
   localparam logic [7:0] OFS_OP_STATE = 8'h0B;
   localparam logic [7:0] OFS_INT_ORIGIN = 8'h0C;
   localparam logic [7:0] OFS_ORIENT_STATUS = 8'h10;
   localparam logic [7:0] OFS_FFMT_SRC = 8'h16;
   localparam logic [7:0] OFS_TRANS_SRC = 8'h1E;
   localparam logic [7:0] OFS_PULSE_SRC = 8'h22;
   localparam logic [7:0] OFS_MAG_FIRST = 8'h33;
   localparam logic [7:0] OFS_MAG_LAST = 8'h38;
   localparam logic [7:0] OFS_MAG_INT_SRC = 8'h5E;
   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int unsigned BIT_ASLP = 7;
   localparam int unsigned BIT_FIFO = 6;
   localparam int unsigned BIT_TRANS = 5;
   localparam int unsigned BIT_ORIENT = 4;
   localparam int unsigned BIT_PULSE = 3;
   localparam int unsigned BIT_FFMT = 2;
   localparam int unsigned BIT_AVECM = 1;
   localparam int unsigned BIT_DRDY = 0;
   localparam int unsigned AGE_W = 5;
   localparam logic [AGE_W-1:0] AGE_MAX = 5'h1F;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] INACT_RST = 8'h00;
   // ----------------------------------------------------------------
   // Mode codes and sensor selection
   // ----------------------------------------------------------------
   localparam logic [1:0] CODE_STANDBY = 2'h0;
   localparam logic [1:0] CODE_WAKE = 2'h1;
   localparam logic [1:0] CODE_SLEEP = 2'h2;
   localparam logic [1:0] SEL_ACC = 2'h0;
   localparam logic [1:0] SEL_MAG = 2'h1;
   localparam logic [1:0] SEL_HYB = 2'h3;
   typedef enum logic [1:0] {SMI_STANDBY, SMI_WAKE, SMI_SLEEP} smi_mode_e;
endpackage
`default_nettype wire

// ==== include/smi_flag_if.sv ====
// Set, clear and state vectors of the sticky flag bank
`default_nettype none
interface smi_flag_if #(parameter int W = 8);
   logic [W-1:0] set;
   logic [W-1:0] clr;
   logic [W-1:0] flags;
   modport bank(input set, input clr, output flags);
   modport ctrl(output set, output clr, input flags);
endinterface
`default_nettype wire

// ==== core/smi_flag_bank.sv ====
// Sticky flag bank in which a set beats a clear in the same cycle
`default_nettype none
module smi_flag_bank #(
   parameter int W = 8
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   smi_flag_if.bank f
);
   // ----------------------------------------------------------------
   // Flags
   // ----------------------------------------------------------------
   // Clear first, then set, so an event in the clearing cycle survives
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         f.flags <= '0;
      end else begin
         f.flags <= (f.flags & ~f.clr) | f.set;
      end
   end
endmodule
`default_nettype wire

// ==== core/smi_burst_ptr.sv ====
// Read address pointer with the hybrid sensor-data burst wrap
`default_nettype none
module smi_burst_ptr
   import smi_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic rd_start,
   input wire logic rd_next,
   input wire logic [7:0] rd_addr,
   input wire logic hyb_burst,
   output logic [7:0] eff_addr,
   output logic fire
);
   // ----------------------------------------------------------------
   // Next address
   // ----------------------------------------------------------------
   function automatic logic [7:0] next_addr(input logic [7:0] a, input logic hyb);
      logic [7:0] n;
      n = a + 8'h01;
      if (hyb && a == OFS_ACC_LAST) begin
         n = OFS_MAG_FIRST;
      end else if (hyb && a == OFS_MAG_LAST) begin
         n = OFS_ACC_FIRST;
      end
      return n;
   endfunction

   logic [7:0] ptr;

   assign fire = rd_start | rd_next;
   assign eff_addr = rd_start ? rd_addr : ptr;

   // Twelve bytes: six of acceleration, then six of magnetic data
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ptr <= RST_BYTE;
      end else if (fire) begin
         ptr <= next_addr(eff_addr, hyb_burst);
      end
   end
endmodule
`default_nettype wire

// ==== core/smi_status_top.sv ====
// Operating state status and interrupt origin flags of the motion sensor
// What this block does
// - Read-only state register: gate error bit 7, age [6:2], state [1:0], reset 0.
// - Gate error flag sets on a gate error, clears when the FIFO empties.
// - Age counts data-rate periods since gate error; zero while flag clear.
// - State field codes standby 00, wake 01, sleep 10; resets to standby.
// - Reading the state register clears the auto-sleep/wake flag.
// - Read-only interrupt origin register, eight flags, reset 0.
// - Reading the origin register clears only the vector-magnitude flag.
// - Vector-magnitude flag sets on its event, clears on origin register read.
// - FIFO flag sets on a sample push while overflow or watermark holds; FIFO status read clears it.
// - Transient flag follows event active and enable; its source read clears.
// - Orientation flag follows new orientation and enable; status read clears.
// - Pulse flag follows event active and enable; its source read clears.
// - Freefall/motion flag follows event active and enable; source read clears.
// - Auto-sleep/wake flag sets on wake-to-sleep or sleep-to-wake transitions.
// - Data-ready follows new data chosen by the sensor selection mode.
// - Data-ready clears on acceleration readout in accelerometer mode, or magnetic readout in magnetometer and hybrid modes.
// - Hybrid auto-increment burst returns twelve bytes starting at X high byte.
// - Magnetic interrupt flags live in their own register, not here.
// - After a FIFO status read, next pushed sample re-sets the FIFO flag while overflow or watermark holds.
`default_nettype none
module smi_status_top
   import smi_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic rd_start,
   input wire logic rd_next,
   input wire logic [7:0] rd_addr,
   output logic [7:0] rd_data,
   output logic rd_valid,
   input wire logic active_en,
   input wire logic aslp_en,
   input wire logic [7:0] aslp_count,
   input wire logic wake_evt,
   input wire logic odr_tick,
   input wire logic fifo_gate_err,
   input wire logic fifo_empty,
   input wire logic fifo_push,
   input wire logic fifo_ovf,
   input wire logic fifo_wmrk,
   input wire logic trans_event_active,
   input wire logic trans_int_en,
   input wire logic orient_newlp,
   input wire logic orient_int_en,
   input wire logic pulse_event_active,
   input wire logic pulse_int_en,
   input wire logic ffmt_event_active,
   input wire logic ffmt_int_en,
   input wire logic avecm_evt,
   input wire logic acc_new,
   input wire logic mag_new,
   input wire logic [1:0] sensor_sel,
   input wire logic hyb_autoinc,
   output logic [7:0] operating_state_status,
   output logic [7:0] interrupt_origin_flags,
   output logic [1:0] sys_mode
);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [1:0] mode_code(input smi_mode_e m);
      logic [1:0] c;
      case (m)
         SMI_WAKE: begin
            c = CODE_WAKE;
         end
         SMI_SLEEP: begin
            c = CODE_SLEEP;
         end
         default: begin
            c = CODE_STANDBY;
         end
      endcase
      return c;
   endfunction

   function automatic logic hit(input logic f, input logic [7:0] a, input logic [7:0] o);
      return f && (a == o);
   endfunction

   // ----------------------------------------------------------------
   // Read access
   // ----------------------------------------------------------------
   logic [7:0] eff_addr;
   logic fire;
   logic hyb_burst;

   assign hyb_burst = hyb_autoinc && (sensor_sel == SEL_HYB);

   smi_burst_ptr u_ptr (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .rd_start(rd_start),
      .rd_next(rd_next),
      .rd_addr(rd_addr),
      .hyb_burst(hyb_burst),
      .eff_addr(eff_addr),
      .fire(fire)
   );

   logic rd_op_state;
   logic rd_origin;
   logic rd_fifo_status;
   logic rd_trans_src;
   logic rd_orient_status;
   logic rd_pulse_src;
   logic rd_ffmt_src;
   logic rd_acc_done;
   logic rd_mag_done;

   assign rd_op_state = hit(fire, eff_addr, OFS_OP_STATE);
   assign rd_origin = hit(fire, eff_addr, OFS_INT_ORIGIN);
   assign rd_fifo_status = hit(fire, eff_addr, OFS_FIFO_STATUS);
   assign rd_trans_src = hit(fire, eff_addr, OFS_TRANS_SRC);
   assign rd_orient_status = hit(fire, eff_addr, OFS_ORIENT_STATUS);
   assign rd_pulse_src = hit(fire, eff_addr, OFS_PULSE_SRC);
   assign rd_ffmt_src = hit(fire, eff_addr, OFS_FFMT_SRC);
   // Readout counts as done once the last byte of its group is read
   assign rd_acc_done = hit(fire, eff_addr, OFS_ACC_LAST);
   assign rd_mag_done = hit(fire, eff_addr, OFS_MAG_LAST);

   // ----------------------------------------------------------------
   // Operating state machine
   // ----------------------------------------------------------------
   smi_mode_e mode;
   smi_mode_e next_mode;
   logic [7:0] inact_cnt;
   logic to_sleep;
   logic to_wake;

   // Inactivity is measured in data-rate periods while awake
   assign to_sleep = (mode == SMI_WAKE) && aslp_en && odr_tick && !wake_evt
                     && (inact_cnt >= aslp_count);
   assign to_wake = (mode == SMI_SLEEP) && wake_evt;

   always_comb begin
      next_mode = mode;
      case (mode)
         SMI_STANDBY: begin
            if (active_en) begin
               next_mode = SMI_WAKE;
            end
         end
         SMI_WAKE: begin
            if (!active_en) begin
               next_mode = SMI_STANDBY;
            end else if (to_sleep) begin
               next_mode = SMI_SLEEP;
            end
         end
         SMI_SLEEP: begin
            if (!active_en) begin
               next_mode = SMI_STANDBY;
            end else if (to_wake) begin
               next_mode = SMI_WAKE;
            end
         end
         default: begin
            next_mode = SMI_STANDBY;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         mode <= SMI_STANDBY;
      end else begin
         mode <= next_mode;
      end
   end

   // Saturates so a long quiet spell cannot wrap back below the limit
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         inact_cnt <= INACT_RST;
      end else if (mode != SMI_WAKE || wake_evt || !aslp_en) begin
         inact_cnt <= INACT_RST;
      end else if (odr_tick && inact_cnt != 8'hFF) begin
         inact_cnt <= inact_cnt + 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // FIFO gate error and its age
   // ----------------------------------------------------------------
   logic gate_err;
   logic [AGE_W-1:0] gate_age;

   logic next_gate_err;

   // A new error in the emptying cycle is kept
   always_comb begin
      next_gate_err = gate_err;
      if (fifo_gate_err) begin
         next_gate_err = 1'b1;
      end else if (fifo_empty) begin
         next_gate_err = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         gate_err <= 1'b0;
      end else begin
         gate_err <= next_gate_err;
      end
   end

   // Age holds at its top value rather than wrapping
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         gate_age <= '0;
      end else if (!gate_err || !next_gate_err) begin
         // Zeroed in the same edge as the flag, so no stale age is ever shown without it
         gate_age <= '0;
      end else if (odr_tick && gate_age != AGE_MAX) begin
         gate_age <= gate_age + 5'h01;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt origin flags
   // ----------------------------------------------------------------
   smi_flag_if #(.W(8)) flag_bus ();

   smi_flag_bank #(.W(8)) u_flags (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .f(flag_bus.bank)
   );

   logic drdy_set;
   logic drdy_clr;

   always_comb begin
      case (sensor_sel)
         SEL_ACC: begin
            drdy_set = acc_new;
            drdy_clr = rd_acc_done;
         end
         SEL_MAG: begin
            drdy_set = mag_new;
            drdy_clr = rd_mag_done;
         end
         SEL_HYB: begin
            drdy_set = acc_new | mag_new;
            drdy_clr = rd_mag_done;
         end
         default: begin
            drdy_set = 1'b0;
            drdy_clr = 1'b0;
         end
      endcase
   end

   // A read of the origin register itself clears only the vector flag
   always_comb begin
      flag_bus.set = '0;
      flag_bus.clr = '0;
      flag_bus.set[BIT_ASLP] = to_sleep | to_wake;
      flag_bus.clr[BIT_ASLP] = rd_op_state;
      flag_bus.set[BIT_FIFO] = fifo_push & (fifo_ovf | fifo_wmrk);
      flag_bus.clr[BIT_FIFO] = rd_fifo_status;
      flag_bus.set[BIT_TRANS] = trans_event_active & trans_int_en;
      flag_bus.clr[BIT_TRANS] = rd_trans_src;
      flag_bus.set[BIT_ORIENT] = orient_newlp & orient_int_en;
      flag_bus.clr[BIT_ORIENT] = rd_orient_status;
      flag_bus.set[BIT_PULSE] = pulse_event_active & pulse_int_en;
      flag_bus.clr[BIT_PULSE] = rd_pulse_src;
      flag_bus.set[BIT_FFMT] = ffmt_event_active & ffmt_int_en;
      flag_bus.clr[BIT_FFMT] = rd_ffmt_src;
      flag_bus.set[BIT_AVECM] = avecm_evt;
      flag_bus.clr[BIT_AVECM] = rd_origin;
      flag_bus.set[BIT_DRDY] = drdy_set;
      flag_bus.clr[BIT_DRDY] = drdy_clr;
   end

   // ----------------------------------------------------------------
   // Register images
   // ----------------------------------------------------------------
   logic [7:0] op_state_img;

   // Mode field built from the enum only, so code 11 cannot appear
   assign op_state_img = {gate_err, gate_age, mode_code(mode)};

   assign operating_state_status = op_state_img;
   assign interrupt_origin_flags = flag_bus.flags;
   assign sys_mode = mode_code(mode);

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   // Data is the image before the read's own clearing takes effect.
   // Magnetic interrupt flags stay out of this block entirely, so their
   // register reads zero here and is merged by its owner.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rd_data <= RST_BYTE;
      end else if (fire) begin
         case (eff_addr)
            OFS_OP_STATE: begin
               rd_data <= op_state_img;
            end
            OFS_INT_ORIGIN: begin
               rd_data <= flag_bus.flags;
            end
            OFS_MAG_INT_SRC: begin
               rd_data <= RST_BYTE;
            end
            default: begin
               rd_data <= RST_BYTE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= fire;
      end
   end
endmodule
`default_nettype wire

// ==== tb/smi_checker.sv ====
// Concurrent checks on the ports of the status block
`default_nettype none
module smi_checker
   import smi_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic rd_start,
   input wire logic [7:0] rd_addr,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid,
   input wire logic odr_tick,
   input wire logic fifo_gate_err,
   input wire logic fifo_empty,
   input wire logic trans_event_active,
   input wire logic trans_int_en,
   input wire logic avecm_evt,
   input wire logic [7:0] operating_state_status,
   input wire logic [7:0] interrupt_origin_flags,
   input wire logic [1:0] sys_mode
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // ----
   // Properties
   // ----
   chk_state_read: assert property (rd_start && rd_addr == OFS_OP_STATE |=>
      rd_valid && rd_data == $past(operating_state_status)) else $error("state read data wrong");
   chk_mag_absent: assert property (rd_start && rd_addr == OFS_MAG_INT_SRC |=>
      rd_valid && rd_data == 8'h00) else $error("magnetic source not empty");
   chk_mode_legal: assert property (sys_mode != 2'h3) else $error("unused mode code");
   chk_mode_field: assert property (operating_state_status[1:0] == sys_mode)
      else $error("mode field mismatch");
   chk_gerr_set: assert property (fifo_gate_err |=> operating_state_status[7])
      else $error("gate error not set");
   chk_gerr_clear: assert property (fifo_empty && !fifo_gate_err |=> !operating_state_status[7])
      else $error("gate error not cleared");
   chk_age_zero: assert property (!operating_state_status[7] |-> operating_state_status[6:2] == 5'h00)
      else $error("age not zero");
   // Saturation is excluded so the step check cannot fire at the ceiling
   chk_age_step: assert property (operating_state_status[7] && odr_tick && !fifo_empty &&
      operating_state_status[6:2] != AGE_MAX |=>
      operating_state_status[6:2] == $past(operating_state_status[6:2]) + 5'h01)
      else $error("age step wrong");
   chk_aslp_clear: assert property (rd_start && rd_addr == OFS_OP_STATE ##1 $stable(sys_mode) |->
      !interrupt_origin_flags[BIT_ASLP]) else $error("sleep flag kept");
   chk_avecm_set: assert property (avecm_evt |=> interrupt_origin_flags[BIT_AVECM])
      else $error("vector flag not set");
   chk_avecm_clear: assert property (rd_start && rd_addr == OFS_INT_ORIGIN && !avecm_evt |=>
      !interrupt_origin_flags[BIT_AVECM]) else $error("vector flag kept");
   chk_origin_keep: assert property (rd_start && rd_addr == OFS_INT_ORIGIN |=>
      ($past(interrupt_origin_flags) & 8'hFD & ~interrupt_origin_flags) == 8'h00) else $error("flag lost on read");
   chk_trans_set: assert property (trans_event_active && trans_int_en |=> interrupt_origin_flags[BIT_TRANS])
      else $error("transient flag not set");
   cov_sleep: cover property (sys_mode == CODE_SLEEP);
   cov_age_max: cover property (operating_state_status[6:2] == AGE_MAX);
   cov_burst: cover property (rd_start && rd_addr == OFS_ACC_FIRST);
endmodule
bind smi_status_top smi_checker u_smi_checker (.clk_sys, .sys_rst, .rd_start, .rd_addr, .rd_data, .rd_valid,
   .odr_tick, .fifo_gate_err, .fifo_empty, .trans_event_active, .trans_int_en, .avecm_evt,
   .operating_state_status, .interrupt_origin_flags, .sys_mode);
`default_nettype wire

// ==== tb/smi_host.sv ====
// Host model that issues register reads and collects the answers
`default_nettype none
module smi_host (
   input wire logic clk_sys,
   input wire logic rd_valid,
   input wire logic [7:0] rd_data,
   output logic rd_start,
   output logic rd_next,
   output logic [7:0] rd_addr
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] q[$];
   initial begin
      rd_start = 1'b0;
      rd_next = 1'b0;
      rd_addr = 8'hA5;
   end
   // ----
   // Burst of n bytes; the address is inverted when unused so a stale value never passes for a real one
   // ----
   task read(input logic [7:0] a, input int n);
      q.delete();
      for (int i = 0; i <= n; i++) begin
         @(posedge clk_sys);
         rd_start <= (i == 0);
         rd_next <= (i > 0 && i < n);
         rd_addr <= (i == 0) ? a : ~a;
         @(negedge clk_sys);
         if (i > 0 && rd_valid === 1'b1) q.push_back(rd_data);
      end
   endtask
endmodule
`default_nettype wire

// ==== tb/system_mode_and_interrupt_source_bench.sv ====
// Self-checking bench for the mode and interrupt source status block
`default_nettype none
module system_mode_and_interrupt_source_bench import smi_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [6:0] p = 7'h00;
   logic [5:0] lvl = 6'h00;
   logic [3:0] src = 4'h0;
   logic [3:0] en = 4'h0;
   logic [1:0] sensor_sel = 2'h0;
   logic [7:0] aslp_count = 8'h00;
   logic rd_start, rd_next, rd_valid;
   logic [7:0] rd_addr, rd_data, st, fl;
   logic [1:0] sys_mode;
   logic [7:0] ofs [4] = '{OFS_TRANS_SRC, OFS_ORIENT_STATUS, OFS_PULSE_SRC, OFS_FFMT_SRC};
   int err_total = 0;
   int comparisons = 0;
   int cyc_cnt = 0;
   smi_status_top u_smi_status_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .rd_start(rd_start),
      .rd_next(rd_next), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .active_en(lvl[0]),
      .aslp_en(lvl[1]), .aslp_count(aslp_count), .wake_evt(p[0]), .odr_tick(p[1]), .fifo_gate_err(p[2]),
      .fifo_empty(lvl[2]), .fifo_push(p[3]), .fifo_ovf(lvl[3]), .fifo_wmrk(lvl[4]),
      .trans_event_active(src[0]), .trans_int_en(en[0]), .orient_newlp(src[1]), .orient_int_en(en[1]),
      .pulse_event_active(src[2]), .pulse_int_en(en[2]), .ffmt_event_active(src[3]), .ffmt_int_en(en[3]),
      .avecm_evt(p[4]), .acc_new(p[5]), .mag_new(p[6]), .sensor_sel(sensor_sel), .hyb_autoinc(lvl[5]),
      .operating_state_status(st), .interrupt_origin_flags(fl), .sys_mode(sys_mode));
   smi_host u_smi_host (.clk_sys(clk_sys), .rd_valid(rd_valid), .rd_data(rd_data), .rd_start(rd_start),
      .rd_next(rd_next), .rd_addr(rd_addr));
   always #2.5 clk_sys = ~clk_sys;
   // ----
   // Helpers
   // ----
   task summarize;
      if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // The whole run needs well under a thousand cycles
   always @(posedge clk_sys) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 5000) begin
         err_total = err_total + 1;
         summarize();
      end
   end
   task chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   task pulse(input int i);
      @(posedge clk_sys) p[i] <= 1'b1;
      @(posedge clk_sys) p[i] <= 1'b0;
      @(negedge clk_sys);
   endtask
   task setl(input int i, input logic v);
      @(posedge clk_sys) lvl[i] <= v;
      cyc(2);
   endtask
   task rd(input logic [7:0] a, input int n);
      u_smi_host.read(a, n);
   endtask
   // ----
   // Scenarios
   // ----
   task t_reset;
      chk(st, RST_BYTE);
      chk(fl, RST_BYTE);
      chk({6'h00, sys_mode}, {6'h00, CODE_STANDBY});
      rd(OFS_MAG_INT_SRC, 1);
      chk(u_smi_host.q[0], 8'h00);
   endtask
   task t_mode;
      int k;
      setl(0, 1'b1);
      // Leaving standby is neither auto-sleep transition, so no flag here
      chk({fl[7], 5'h00, sys_mode}, {1'b0, 5'h00, CODE_WAKE});
      rd(OFS_OP_STATE, 1);
      chk(u_smi_host.q[0], {6'h00, CODE_WAKE});
      chk(fl, 8'h00);
      @(posedge clk_sys) aslp_count <= 8'h02;
      setl(1, 1'b1);
      for (k = 0; k < 8 && sys_mode !== CODE_SLEEP; k++) pulse(1);
      chk(k[7:0], 8'h03);
      chk(fl, 8'h80);
      rd(OFS_OP_STATE, 1);
      chk(u_smi_host.q[0], {6'h00, CODE_SLEEP});
      pulse(0);
      chk({fl[7], 5'h00, sys_mode}, {1'b1, 5'h00, CODE_WAKE});
      setl(0, 1'b0);
      rd(OFS_OP_STATE, 1);
      chk({fl[7], 5'h00, sys_mode}, 8'h00);
   endtask
   task t_gate;
      pulse(2);
      chk(st, 8'h80);
      repeat (3) pulse(1);
      chk(st, 8'h8C);
      repeat (30) pulse(1);
      chk(st, 8'hFC);
      setl(2, 1'b1);
      chk(st, 8'h00);
      setl(2, 1'b0);
   endtask
   task t_level;
      logic [7:0] e;
      for (int i = 0; i < 4; i++) begin
         e = 8'h20 >> i;
         @(posedge clk_sys) src[i] <= 1'b1;
         cyc(2);
         chk(fl, 8'h00);
         @(posedge clk_sys) en[i] <= 1'b1;
         cyc(2);
         @(posedge clk_sys) src[i] <= 1'b0;
         en[i] <= 1'b0;
         rd(OFS_INT_ORIGIN, 1);
         chk(u_smi_host.q[0], e);
         chk(fl, e);
         rd(ofs[i], 1);
         chk(fl, 8'h00);
      end
   endtask
   task t_avecm;
      pulse(4);
      rd(OFS_INT_ORIGIN, 1);
      chk(u_smi_host.q[0], 8'h02);
      chk(fl, 8'h00);
   endtask
   task t_fifo;
      setl(4, 1'b1);
      chk(fl, 8'h00);
      pulse(3);
      chk(fl, 8'h40);
      rd(OFS_FIFO_STATUS, 1);
      chk(fl, 8'h00);
      pulse(3);
      chk(fl, 8'h40);
      setl(4, 1'b0);
      setl(3, 1'b1);
      rd(OFS_FIFO_STATUS, 1);
      pulse(3);
      chk(fl, 8'h40);
      setl(3, 1'b0);
      rd(OFS_FIFO_STATUS, 1);
      pulse(3);
      chk(fl, 8'h00);
   endtask
   task t_drdy;
      pulse(5);
      chk(fl, 8'h01);
      rd(OFS_ACC_LAST, 1);
      chk(fl, 8'h00);
      @(posedge clk_sys) sensor_sel <= SEL_MAG;
      pulse(5);
      chk(fl, 8'h00);
      pulse(6);
      rd(OFS_ACC_LAST, 1);
      chk(fl, 8'h01);
      rd(OFS_MAG_LAST, 1);
      chk(fl, 8'h00);
      @(posedge clk_sys) sensor_sel <= SEL_HYB;
      setl(5, 1'b1);
      pulse(6);
      rd(OFS_ACC_FIRST, 12);
      chk(8'(u_smi_host.q.size()), 8'h0C);
      chk(fl, 8'h00);
   endtask
   initial begin
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      cyc(1);
      t_reset();
      t_mode();
      t_gate();
      t_level();
      t_avecm();
      t_fifo();
      t_drdy();
      summarize();
   end
endmodule
`default_nettype wire
